// ---- rtl/vcom_bridge.sv ----
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module vcom_bridge (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB register port.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link.
	vcom_if.ctrl_end         link
);

	// Each register is one aligned word with its data in the low bits.
	// CTRL holds the handshake mode: disabled, rts, cts or rtscts.
	// DIV holds clock cycles per bit, clamped to the legal baud range.
	// TX takes one character for the target; RX pops the oldest one received.
	// STAT shows transmit full, receive valid, overrun and transmitter busy.
	// Writing one to the overrun bit clears it.
	// An unmapped address answers with an error and changes nothing.
	// Every access sees exactly one wait state before ready.

	typedef struct packed {
		vcom_pkg::hs_mode_t mode;
		logic [15:0]        div;
		logic [7:0]         txd;
		logic               tx_full;
		// Two-flop synchronisers for the link inputs.
		logic               tx_m;
		logic               tx_q;
		logic               rts_m;
		logic               rts_q;
		logic               en_m;
		logic               en_q;
		// Serial engines, down to the target and up from it.
		vcom_pkg::uart_t    dn;
		vcom_pkg::uart_t    up;
		// Two-character receive buffer and its fill count.
		logic [7:0]         b0;
		logic [7:0]         b1;
		logic [1:0]         cnt;
		logic               ovr;
		logic               line;
		logic               cts;
		logic               cts_oe;
		// Registered bus answer.
		logic [31:0]        prdata;
		logic               pready;
		logic               pslverr;
	} bc_state_t;

	localparam bc_state_t RST = '{
		mode:    vcom_pkg::HS_DISABLED,
		div:     vcom_pkg::DIV_DEF,
		tx_m:    1'b1,
		tx_q:    1'b1,
		line:    1'b1,
		cts:     1'b1,
		dn:      vcom_pkg::UART_IDLE,
		up:      vcom_pkg::UART_IDLE,
		default: '0
	};

	bc_state_t  s_r;
	bc_state_t  s_nxt;
	logic       acc;
	logic       wr;
	logic       rd;
	logic       start;
	logic       rx_fc;
	logic       in_line;
	logic [1:0] c;

	assign acc     = psel && penable && s_r.pready && !s_r.pslverr;
	assign wr      = acc && pwrite;
	assign rd      = acc && !pwrite;
	assign rx_fc   = s_r.mode[1];
	// A character leaves only when the target is ready or its readiness is ignored.
	assign start   = s_r.tx_full && !s_r.dn.busy && (!rx_fc || s_r.rts_q);
	// A disabled link reads as an idle line, so no false start bit is seen.
	assign in_line = s_r.en_q ? s_r.tx_q : 1'b1;

	always_comb begin
		s_nxt = s_r;
		c = s_r.cnt;
		s_nxt.tx_m  = link.tx;
		s_nxt.tx_q  = s_r.tx_m;
		s_nxt.rts_m = link.rts;
		s_nxt.rts_q = s_r.rts_m;
		s_nxt.en_m  = link.enable;
		s_nxt.en_q  = s_r.en_m;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;
		// The answer is prepared on the first access cycle and stands for one cycle.
		if (psel && penable && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = 32'h0;
			if (paddr == vcom_pkg::OFS_CTRL) begin
				s_nxt.prdata = {30'h0, s_r.mode};
			end else if (paddr == vcom_pkg::OFS_DIV) begin
				s_nxt.prdata = {16'h0, s_r.div};
			end else if (paddr == vcom_pkg::OFS_TX) begin
				s_nxt.prdata = 32'h0;
			end else if (paddr == vcom_pkg::OFS_RX) begin
				s_nxt.prdata = (s_r.cnt != 2'h0) ? {24'h0, s_r.b0} : 32'h0;
			end else if (paddr == vcom_pkg::OFS_STAT) begin
				s_nxt.prdata[vcom_pkg::STAT_TXFULL] = s_r.tx_full;
				s_nxt.prdata[vcom_pkg::STAT_RXVAL]  = s_r.cnt != 2'h0;
				s_nxt.prdata[vcom_pkg::STAT_OVR]    = s_r.ovr;
				s_nxt.prdata[vcom_pkg::STAT_BUSY]   = s_r.dn.busy;
			end else begin
				s_nxt.pslverr = 1'b1;
			end
		end

		// A started character always runs to its stop bit.
		s_nxt.dn = vcom_pkg::tx_step(s_r.dn, start, s_r.txd, s_r.div);
		if (start) begin
			s_nxt.tx_full = 1'b0;
		end

		// Register writes take effect on the edge at which ready is seen high.
		if (wr) begin
			if (paddr == vcom_pkg::OFS_CTRL) begin
				s_nxt.mode = vcom_pkg::hs_mode_t'(pwdata[1:0]);
			end else if (paddr == vcom_pkg::OFS_DIV) begin
				// Out-of-range divisors are pulled to the nearest legal rate, not refused.
				if (pwdata[31:16] != 16'h0 || pwdata[15:0] > vcom_pkg::DIV_MAX) begin
					s_nxt.div = vcom_pkg::DIV_MAX;
				end else if (pwdata[15:0] < vcom_pkg::DIV_MIN) begin
					s_nxt.div = vcom_pkg::DIV_MIN;
				end else begin
					s_nxt.div = pwdata[15:0];
				end
			end else if (paddr == vcom_pkg::OFS_TX) begin
				// A write while a character still waits is dropped; software polls full.
				if (!s_r.tx_full) begin
					s_nxt.txd     = pwdata[7:0];
					s_nxt.tx_full = 1'b1;
				end
			end else if (paddr == vcom_pkg::OFS_STAT) begin
				// Overrun is set further down, so a new overrun in this cycle wins.
				if (pwdata[vcom_pkg::STAT_OVR]) begin
					s_nxt.ovr = 1'b0;
				end
			end
		end

		// A pop comes before a new character, so a full buffer can take it.
		if (rd && paddr == vcom_pkg::OFS_RX && c != 2'h0) begin
			s_nxt.b0 = s_r.b1;
			c = c - 2'h1;
		end
		s_nxt.up = vcom_pkg::rx_step(s_r.up, in_line, s_r.div);
		if (s_nxt.up.done) begin
			if (c == 2'h0) begin
				s_nxt.b0 = s_nxt.up.sh[9:2];
				c = 2'h1;
			end else if (c == 2'h1) begin
				s_nxt.b1 = s_nxt.up.sh[9:2];
				c = 2'h2;
			end else begin
				s_nxt.ovr = 1'b1;
			end
		end

		s_nxt.cnt = c;
		// One word held counts as full; the spare slot takes a character in flight.
		s_nxt.cts    = c == 2'h0;
		s_nxt.cts_oe = s_nxt.mode[0];
		s_nxt.line   = s_nxt.dn.busy ? s_nxt.dn.sh[0] : 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata      = s_r.prdata;
	assign pready      = s_r.pready;
	assign pslverr     = s_r.pslverr;
	assign link.rx     = s_r.line;
	assign link.cts_o  = s_r.cts;
	assign link.cts_oe = s_r.cts_oe;

endmodule

// ---- rtl/vcom_if.sv ----
`timescale 1ns/100ps
interface vcom_if;
	logic tx;
	logic rx;
	logic cts_o;
	logic cts_oe;
	logic cts;
	logic rts;
	logic enable;

	// An undriven clear-to-send line is pulled to the ready level.
	assign cts = cts_oe ? cts_o : 1'b1;

	modport ctrl_end (
		input  tx,
		input  rts,
		input  enable,
		output rx,
		output cts_o,
		output cts_oe
	);

	modport target_end (
		output tx,
		output rts,
		output enable,
		input  rx,
		input  cts
	);
endinterface

// ---- rtl/vcom_pkg.sv ----
package vcom_pkg;

	localparam int unsigned CLK_HZ   = 10_000_000;
	localparam int unsigned BAUD_DEF = 115_200;
	localparam int unsigned BAUD_MIN = 9_600;
	localparam int unsigned BAUD_MAX = 921_600;
	localparam logic [15:0] DIV_DEF  = 16'(CLK_HZ / BAUD_DEF);
	localparam logic [15:0] DIV_MIN  = 16'(CLK_HZ / BAUD_MAX);
	localparam logic [15:0] DIV_MAX  = 16'(CLK_HZ / BAUD_MIN);
	localparam logic [3:0]  LAST_BIT = 4'h9;
	localparam logic [1:0]  RX_DEPTH = 2'h2;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIV  = 8'h04;
	localparam logic [7:0] OFS_TX   = 8'h08;
	localparam logic [7:0] OFS_RX   = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;

	localparam int CTRL_EN     = 0;
	localparam int CTRL_HS     = 1;
	localparam int CTRL_RTS    = 2;
	localparam int STAT_TXFULL = 0;
	localparam int STAT_RXVAL  = 1;
	localparam int STAT_OVR    = 2;
	localparam int STAT_BUSY   = 3;

	typedef enum logic [1:0] {
		HS_DISABLED = 2'h0,
		HS_RTS      = 2'h1,
		HS_CTS      = 2'h2,
		HS_RTSCTS   = 2'h3
	} hs_mode_t;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [3:0]  bitn;
		logic [15:0] cnt;
		logic [9:0]  sh;
	} uart_t;

	localparam uart_t UART_IDLE = '{busy: 1'b0, done: 1'b0, bitn: 4'h0, cnt: 16'h0, sh: 10'h3FF};

	// Start, eight data bits LSB first, stop; the line idles high.
	function automatic uart_t tx_step(uart_t u, logic start, logic [7:0] d, logic [15:0] div);
		uart_t r;
		r = u;
		r.done = 1'b0;
		if (!u.busy) begin
			if (start) begin
				r.busy = 1'b1;
				r.bitn = 4'h0;
				r.cnt  = div - 16'h1;
				r.sh   = {1'b1, d, 1'b0};
			end
		end else if (u.cnt != 16'h0) begin
			r.cnt = u.cnt - 16'h1;
		end else if (u.bitn == LAST_BIT) begin
			r.busy = 1'b0;
			r.done = 1'b1;
		end else begin
			r.cnt  = div - 16'h1;
			r.sh   = {1'b1, u.sh[9:1]};
			r.bitn = u.bitn + 4'h1;
		end
		return r;
	endfunction

	// Samples mid-bit; done pulses when a frame ends with a high stop bit.
	function automatic uart_t rx_step(uart_t u, logic line, logic [15:0] div);
		uart_t r;
		r = u;
		r.done = 1'b0;
		if (!u.busy) begin
			if (!line) begin
				r.busy = 1'b1;
				r.bitn = 4'h0;
				r.cnt  = div >> 1;
			end
		end else if (u.cnt != 16'h0) begin
			r.cnt = u.cnt - 16'h1;
		end else if (u.bitn == 4'h0 && line) begin
			r.busy = 1'b0;
		end else if (u.bitn == LAST_BIT) begin
			r.busy = 1'b0;
			r.done = line;
		end else begin
			r.cnt  = div - 16'h1;
			r.sh   = {line, u.sh[9:1]};
			r.bitn = u.bitn + 4'h1;
		end
		return r;
	endfunction

endpackage

// ---- rtl/vcom_target.sv ----
`timescale 1ns/100ps
module vcom_target (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB register port.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link.
	vcom_if.target_end       link
);

	typedef struct packed {
		logic [2:0]      ctrl;
		logic [15:0]     div;
		logic [7:0]      txd;
		logic            tx_full;
		logic            rx_m;
		logic            rx_q;
		logic            cts_m;
		logic            cts_q;
		vcom_pkg::uart_t up;
		vcom_pkg::uart_t dn;
		logic [7:0]      b0;
		logic [7:0]      b1;
		logic [1:0]      cnt;
		logic            ovr;
		logic            line;
		logic            rts;
		logic            en;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
	} tg_state_t;

	localparam tg_state_t RST = '{
		div: vcom_pkg::DIV_DEF, rx_m: 1'b1, rx_q: 1'b1, line: 1'b1,
		up: vcom_pkg::UART_IDLE, dn: vcom_pkg::UART_IDLE, default: '0
	};

	tg_state_t  s_r;
	tg_state_t  s_nxt;
	logic       acc;
	logic       wr;
	logic       rd;
	logic       start;
	logic [1:0] c;

	assign acc   = psel && penable && s_r.pready && !s_r.pslverr;
	assign wr    = acc && pwrite;
	assign rd    = acc && !pwrite;
	assign start = s_r.tx_full && !s_r.up.busy && s_r.ctrl[vcom_pkg::CTRL_EN]
		&& (!s_r.ctrl[vcom_pkg::CTRL_HS] || s_r.cts_q);

	always_comb begin
		s_nxt = s_r;
		c = s_r.cnt;
		s_nxt.rx_m  = link.rx;
		s_nxt.rx_q  = s_r.rx_m;
		s_nxt.cts_m = link.cts;
		s_nxt.cts_q = s_r.cts_m;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;
		if (psel && penable && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = 32'h0;
			if (paddr == vcom_pkg::OFS_CTRL) begin
				s_nxt.prdata = {29'h0, s_r.ctrl};
			end else if (paddr == vcom_pkg::OFS_DIV) begin
				s_nxt.prdata = {16'h0, s_r.div};
			end else if (paddr == vcom_pkg::OFS_TX) begin
				s_nxt.prdata = 32'h0;
			end else if (paddr == vcom_pkg::OFS_RX) begin
				s_nxt.prdata = (s_r.cnt != 2'h0) ? {24'h0, s_r.b0} : 32'h0;
			end else if (paddr == vcom_pkg::OFS_STAT) begin
				s_nxt.prdata[vcom_pkg::STAT_TXFULL] = s_r.tx_full;
				s_nxt.prdata[vcom_pkg::STAT_RXVAL]  = s_r.cnt != 2'h0;
				s_nxt.prdata[vcom_pkg::STAT_OVR]    = s_r.ovr;
				s_nxt.prdata[vcom_pkg::STAT_BUSY]   = s_r.up.busy;
			end else begin
				s_nxt.pslverr = 1'b1;
			end
		end
		s_nxt.up = vcom_pkg::tx_step(s_r.up, start, s_r.txd, s_r.div);
		if (start) begin
			s_nxt.tx_full = 1'b0;
		end
		if (wr) begin
			if (paddr == vcom_pkg::OFS_CTRL) begin
				s_nxt.ctrl = pwdata[2:0];
			end else if (paddr == vcom_pkg::OFS_DIV) begin
				s_nxt.div = pwdata[15:0];
			end else if (paddr == vcom_pkg::OFS_TX) begin
				if (!s_r.tx_full) begin
					s_nxt.txd     = pwdata[7:0];
					s_nxt.tx_full = 1'b1;
				end
			end else if (paddr == vcom_pkg::OFS_STAT) begin
				if (pwdata[vcom_pkg::STAT_OVR]) begin
					s_nxt.ovr = 1'b0;
				end
			end
		end
		if (rd && paddr == vcom_pkg::OFS_RX && c != 2'h0) begin
			s_nxt.b0 = s_r.b1;
			c = c - 2'h1;
		end
		s_nxt.dn = vcom_pkg::rx_step(s_r.dn, s_r.rx_q, s_r.div);
		if (s_nxt.dn.done) begin
			if (c == 2'h0) begin
				s_nxt.b0 = s_nxt.dn.sh[9:2];
				c = 2'h1;
			end else if (c == 2'h1) begin
				s_nxt.b1 = s_nxt.dn.sh[9:2];
				c = 2'h2;
			end else begin
				s_nxt.ovr = 1'b1;
			end
		end
		s_nxt.cnt  = c;
		// Ready is withheld until software enables it, then drops while a word waits.
		s_nxt.rts  = s_nxt.ctrl[vcom_pkg::CTRL_RTS] && c == 2'h0;
		s_nxt.en   = s_nxt.ctrl[vcom_pkg::CTRL_EN];
		s_nxt.line = s_nxt.up.busy ? s_nxt.up.sh[0] : 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata      = s_r.prdata;
	assign pready      = s_r.pready;
	assign pslverr     = s_r.pslverr;
	assign link.tx     = s_r.line;
	assign link.rts    = s_r.rts;
	assign link.enable = s_r.en;

endmodule

// ---- verif/vcom_link_props.sv ----
`timescale 1ns/100ps
module vcom_link_props #(
	parameter int DIV = 10
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Link lines.
	input wire logic tx,
	input wire logic rx,
	input wire logic cts_oe,
	input wire logic rts,
	input wire logic enable
);
	localparam int FRAME   = 10 * DIV;
	localparam int STOP_AT = 9 * DIV + DIV / 2;

	logic [15:0] tc_r;
	logic [15:0] rc_r;

	// Cycles since the start edge of the frame in flight on each line, zero while idle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tc_r <= 16'h0;
			rc_r <= 16'h0;
		end else begin
			tc_r <= (tc_r == 16'h0) ? {15'h0, !tx} : ((tc_r == 16'(FRAME - 1)) ? 16'h0 : tc_r + 16'h1);
			rc_r <= (rc_r == 16'h0) ? {15'h0, !rx} : ((rc_r == 16'(FRAME - 1)) ? 16'h0 : rc_r + 16'h1);
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_rst_idle;
		$rose(presetn) |-> tx && rx && !cts_oe && !rts && !enable;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");

	property p_tx_en;
		(tc_r == 16'h0 && !tx) |-> enable;
	endproperty
	a_tx_en: assert property (p_tx_en) else $error("frame sent while link disabled");

	property p_tx_start;
		(tc_r == 16'h0 && !tx) |-> !tx [*8];
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("short start bit on tx");

	property p_tx_stop;
		(tc_r == 16'h0 && !tx) |-> ##STOP_AT tx;
	endproperty
	a_tx_stop: assert property (p_tx_stop) else $error("stop bit low on tx");

	property p_tx_hold;
		(tc_r != 16'h0 && int'(tc_r) % DIV != 0) |-> $stable(tx);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx bit changed mid bit");

	property p_rx_start;
		(rc_r == 16'h0 && !rx) |-> !rx [*8];
	endproperty
	a_rx_start: assert property (p_rx_start) else $error("short start bit on rx");

	property p_rx_stop;
		(rc_r == 16'h0 && !rx) |-> ##STOP_AT rx;
	endproperty
	a_rx_stop: assert property (p_rx_stop) else $error("stop bit low on rx");

	property p_rx_hold;
		(rc_r != 16'h0 && int'(rc_r) % DIV != 0) |-> $stable(rx);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx bit changed mid bit");
endmodule

// ---- verif/vcom_uart_flow_control_tb.sv ----
`timescale 1ns/100ps
module vcom_uart_flow_control_tb;
	logic              pclk       = 1'b0;
	logic              presetn    = 1'b0;
	logic        [1:0] psel       = 2'h0;
	logic              penable    = 1'b0;
	logic              pwrite     = 1'b0;
	logic        [7:0] paddr      = 8'h0;
	logic       [31:0] pwdata     = 32'h0;
	wire  [1:0] [31:0] prdata;
	wire         [1:0] pready;
	wire         [1:0] pslverr;
	logic              perr;
	logic       [31:0] q;
	logic       [31:0] v;
	logic        [7:0] b;
	int                seed       = 32'h0bbb;
	int                fail_count = 0;
	int                num_checks = 0;
	int                cyc        = 0;
	int                i;
	int                m;

	vcom_if u_vcom_if ();
	vcom_bridge u_vcom_bridge (
		.pclk(pclk), .presetn(presetn), .psel(psel[0]), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata[0]),
		.pready(pready[0]), .pslverr(pslverr[0]), .link(u_vcom_if.ctrl_end)
	);
	vcom_target u_vcom_target (
		.pclk(pclk), .presetn(presetn), .psel(psel[1]), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata[1]),
		.pready(pready[1]), .pslverr(pslverr[1]), .link(u_vcom_if.target_end)
	);
	vcom_link_props #(.DIV(10)) u_vcom_link_props (
		.pclk(pclk), .presetn(presetn), .tx(u_vcom_if.tx), .rx(u_vcom_if.rx),
		.cts_oe(u_vcom_if.cts_oe), .rts(u_vcom_if.rts), .enable(u_vcom_if.enable)
	);

	always #50 pclk = ~pclk;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer on end s (0 bridge, 1 target); read data lands in q.
	task automatic apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel[s] <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready[s] !== 1'b1);
		q = prdata[s];
		perr = pslverr[s];
		psel <= 2'h0;
		penable <= 1'b0;
	endtask

	task automatic wrx(input int s);
		do begin
			apb(s, 1'b0, vcom_pkg::OFS_STAT, 32'h0);
		end while (q[vcom_pkg::STAT_RXVAL] !== 1'b1);
	endtask

	function automatic logic [31:0] clampd(input logic [31:0] d);
		if (d < 32'(vcom_pkg::DIV_MIN)) return 32'(vcom_pkg::DIV_MIN);
		if (d > 32'(vcom_pkg::DIV_MAX)) return 32'(vcom_pkg::DIV_MAX);
		return d;
	endfunction

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			tally_and_finish;
		end
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 1'b0, vcom_pkg::OFS_DIV, 32'h0);
		chk(q, 32'(vcom_pkg::DIV_DEF));
		apb(0, 1'b0, vcom_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		chk(32'(u_vcom_if.cts_oe), 32'h0);
		apb(0, 1'b0, 8'h20, 32'h0);
		chk(32'(perr), 32'h1);
		for (i = 0; i < 3; i++) begin
			v = (i == 0) ? 32'h1 : ((i == 1) ? 32'h0000EA60 : (32'($random(seed)) & 32'h7FF));
			apb(0, 1'b1, vcom_pkg::OFS_DIV, v);
			apb(0, 1'b0, vcom_pkg::OFS_DIV, 32'h0);
			chk(q, clampd(v));
		end
		apb(0, 1'b1, vcom_pkg::OFS_DIV, 32'hA);
		apb(1, 1'b1, vcom_pkg::OFS_DIV, 32'hA);
		for (m = 0; m < 4; m++) begin
			apb(0, 1'b1, vcom_pkg::OFS_CTRL, 32'(m));
			apb(1, 1'b1, vcom_pkg::OFS_CTRL, 32'h7);
			chk(32'(u_vcom_if.cts_oe), 32'(m % 2));
			b = 8'($random(seed));
			apb(1, 1'b1, vcom_pkg::OFS_TX, {24'h0, b});
			wrx(0);
			repeat (4) @(posedge pclk);
			chk(32'(u_vcom_if.cts), 32'(m % 2 == 0));
			apb(0, 1'b0, vcom_pkg::OFS_RX, 32'h0);
			chk(q, {24'h0, b});
			// Target withholds readiness before the bridge has anything to send.
			apb(1, 1'b1, vcom_pkg::OFS_CTRL, 32'h3);
			b = 8'($random(seed));
			apb(0, 1'b1, vcom_pkg::OFS_TX, {24'h0, b});
			repeat (150) @(posedge pclk);
			apb(1, 1'b0, vcom_pkg::OFS_STAT, 32'h0);
			chk(32'(q[vcom_pkg::STAT_RXVAL]), 32'(m < 2));
			chk(32'(u_vcom_if.cts), 32'h1);
			apb(1, 1'b1, vcom_pkg::OFS_CTRL, 32'h7);
			wrx(1);
			chk(32'(u_vcom_if.rts), 32'h0);
			apb(1, 1'b0, vcom_pkg::OFS_RX, 32'h0);
			chk(q, {24'h0, b});
		end
		// Disabled handshake: the bridge keeps sending past a held-off target.
		apb(0, 1'b1, vcom_pkg::OFS_CTRL, 32'h0);
		v = 32'($random(seed));
		for (i = 0; i < 3; i++) begin
			apb(0, 1'b1, vcom_pkg::OFS_TX, {24'h0, v[8 * i +: 8]});
			repeat (130) @(posedge pclk);
		end
		chk(32'(u_vcom_if.rts), 32'h0);
		apb(1, 1'b0, vcom_pkg::OFS_STAT, 32'h0);
		chk(q, (32'h1 << vcom_pkg::STAT_RXVAL) | (32'h1 << vcom_pkg::STAT_OVR));
		apb(1, 1'b0, vcom_pkg::OFS_RX, 32'h0);
		chk(q, {24'h0, v[7:0]});
		apb(1, 1'b0, vcom_pkg::OFS_RX, 32'h0);
		chk(q, {24'h0, v[15:8]});
		apb(1, 1'b1, vcom_pkg::OFS_STAT, 32'h1 << vcom_pkg::STAT_OVR);
		apb(1, 1'b0, vcom_pkg::OFS_STAT, 32'h0);
		chk(q, 32'h0);
		tally_and_finish;
	end
endmodule
